// >>> rtl/svs_consts.svh
// Purpose: Offsets, field positions, reset values and times of the supply supervisor
// Assumes: Included by bare name; definitions only
// Notes: Offsets are register indices; byte address is four times the index
`ifndef SVS_CONSTS_SVH
`define SVS_CONSTS_SVH

`define SVS_IDX_CTRL 16'hffbe
`define SVS_IDX_LEVEL 16'hffbf
`define SVS_IDX_CAUSE 16'hffac

`define SVS_CTRL_CMP_EN 7
`define SVS_CTRL_REF_EN 4
`define SVS_CTRL_MODE 1
`define SVS_CTRL_FLAG 0
`define SVS_CTRL_RESET 8'h00

`define SVS_LEVEL_W 3
`define SVS_LEVEL_RESET 3'h0
`define SVS_LEVEL_MAX_FULL 3'h6
`define SVS_LEVEL_MAX_REDUCED 3'h4

`define SVS_CAUSE_UV 0
`define SVS_CAUSE_CLKMON 1
`define SVS_CAUSE_WDT 4
`define SVS_CAUSE_RESET 8'h00

`define SVS_POC_LOW_MV 2850
`define SVS_POC_HIGH_MV 3500
`define SVS_CMP_SETTLE_US 200
`define SVS_REF_SETTLE_US 2000

`endif

// >>> rtl/svs_pkg.sv
// Purpose: Types shared by the supply supervisor
// Assumes: Nothing
// Notes: Constants live in svs_consts.svh
package svs_pkg;
   typedef enum {SVS_POC_OFF, SVS_POC_LOW, SVS_POC_HIGH} svs_poc_e;
   typedef logic [7:0] svs_byte_t;
endpackage

// >>> rtl/svs_sync.sv
// Purpose: Two-flop synchroniser for asynchronous comparator levels
// Assumes: Inputs are slow levels, not pulses
// Notes: First stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none

module svs_sync #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic [WIDTH-1:0] d_async, // Raw levels
   output logic [WIDTH-1:0] q_sync // Synchronised levels
);
   logic [WIDTH-1:0] meta;

   generate
      if (WIDTH < 1)
      begin : g_chk
         $error("svs_sync WIDTH must be at least 1");
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= '0;
         q_sync <= '0;
      end
      else
      begin
         meta <= d_async;
         q_sync <= meta;
      end
   end
endmodule

`default_nettype wire

// >>> rtl/svs_top.sv
// Purpose: Digital side of the supply supervisor: power-on clear and undervoltage detector
// Assumes: Comparator outputs are asynchronous levels; watchdog and clock monitor
//          requests are one-cycle pulses on sys_clk
// Notes: APB slave with zero wait states; rstn models power-up and external reset
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "svs_consts.svh"

// What this block does
// - Power-on clear raises internal reset when enabled
// - Build option: clear off, low or high
// - Power-on clear zeroes the whole cause register
// - Other sources set only their own flag
// - Undervoltage reset sets cause bit zero
// - Control bits 7,4,1,0; others read zero
// - Comparator enable starts or stops detection
// - Reference enable switches the reference generator
// - Mode picks interrupt or reset when low
// - Flag shows supply below level, else zero
// - Flag bit is read-only
// - Non-undervoltage resets clear the control fields
// - Reference enable locked when clear is built in
// - Interrupt follows flag in enabled interrupt mode
// - Seven levels, five on reduced grade
// - Detection keeps working in stop mode
// - Level register: three-bit code, 111 prohibited
module svs_top #(
   parameter svs_pkg::svs_poc_e POC_CONFIG = svs_pkg::SVS_POC_LOW, // Power-on clear option
   parameter bit REDUCED_GRADE = 1'b0 // Reduced temperature grade part
) (
   input wire logic sys_clk, // System clock, 125 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [17:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB write strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic poc_below_raw, // Clear comparator: supply under its voltage
   input wire logic uv_below_raw, // Detector comparator: supply under threshold
   input wire logic wdt_reset_req, // Watchdog reset pulse
   input wire logic clkmon_reset_req, // Clock monitor reset pulse
   input wire logic stop_mode, // Device in stop mode
   output logic internal_reset, // Internal reset to the device, active high
   output logic undervoltage_irq, // Undervoltage interrupt request
   output logic comparator_run, // Analog comparator enable
   output logic reference_run, // Analog reference generator enable
   output logic [2:0] undervoltage_threshold // Selected detection level code
);
   localparam bit POC_ON = (POC_CONFIG != svs_pkg::SVS_POC_OFF);
   localparam logic [2:0] LEVEL_MAX = REDUCED_GRADE ? `SVS_LEVEL_MAX_REDUCED :
      `SVS_LEVEL_MAX_FULL;

   // Reduced grade parts cannot run with the low clear threshold
   generate
      if (REDUCED_GRADE && (POC_CONFIG == svs_pkg::SVS_POC_LOW))
      begin : g_chk
         $error("svs_top: low clear threshold not allowed on reduced grade");
      end
   endgenerate

   logic [1:0] cmp_sync;
   logic poc_s;
   logic uv_s;
   logic comparator_enable;
   logic reference_enable;
   logic response_mode_select;
   svs_pkg::svs_byte_t reset_cause_register;
   svs_pkg::svs_byte_t next_cause;
   logic [2:0] level_code;

   svs_sync #(
      .WIDTH(2)
   ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d_async({poc_below_raw, uv_below_raw}),
      .q_sync(cmp_sync)
   );

   assign poc_s = cmp_sync[1];
   assign uv_s = cmp_sync[0];

   // Detection has no stop-mode gate at all, so it runs on in stop mode
   wire stop_ignored = stop_mode;
   wire poc_event = POC_ON && poc_s;
   wire below_level_flag = comparator_enable && uv_s;
   wire uv_reset_req = below_level_flag && response_mode_select;
   wire uv_irq_req = below_level_flag && !response_mode_select;
   wire other_reset = poc_event || wdt_reset_req || clkmon_reset_req;

   // APB decode
   wire setup = psel && !penable;
   wire access_ok = psel && penable && pready;
   wire hit_ctrl = (paddr[17:2] == `SVS_IDX_CTRL);
   wire hit_level = (paddr[17:2] == `SVS_IDX_LEVEL);
   wire hit_cause = (paddr[17:2] == `SVS_IDX_CAUSE);
   wire hit_any = hit_ctrl || hit_level || hit_cause;
   wire wr_low = access_ok && pwrite && pstrb[0];
   wire ctrl_wr = wr_low && hit_ctrl && !uv_reset_req;
   wire level_wr = wr_low && hit_level;
   wire cause_rd = access_ok && !pwrite && hit_cause;
   wire level_ok = (pwdata[2:0] <= LEVEL_MAX);

   wire [7:0] ctrl_rd = {comparator_enable, 2'h0, reference_enable, 2'h0,
      response_mode_select, below_level_flag};
   wire [7:0] level_rd = {5'h00, level_code};
   wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
      hit_level ? level_rd :
      hit_cause ? reset_cause_register : 8'h00;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !hit_any;
         prdata <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Control fields survive an undervoltage reset but not any other
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         comparator_enable <= 1'b0;
         reference_enable <= 1'b0;
         response_mode_select <= 1'b0;
      end
      else if (other_reset)
      begin
         comparator_enable <= 1'b0;
         reference_enable <= 1'b0;
         response_mode_select <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         comparator_enable <= pwdata[`SVS_CTRL_CMP_EN];
         reference_enable <= POC_ON ? 1'b0 : pwdata[`SVS_CTRL_REF_EN];
         response_mode_select <= pwdata[`SVS_CTRL_MODE];
         // Flag bit of the write data is dropped here
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         level_code <= `SVS_LEVEL_RESET;
      end
      else if (other_reset)
      begin
         level_code <= `SVS_LEVEL_RESET;
      end
      else if (level_wr && level_ok)
      begin
         // Prohibited codes are refused so the level stays valid
         level_code <= pwdata[2:0];
      end
   end

   // Reading the cause register clears it; a new cause in that cycle still lands
   always_comb
   begin
      next_cause = reset_cause_register;
      if (poc_event)
      begin
         next_cause = `SVS_CAUSE_RESET;
      end
      else
      begin
         if (cause_rd)
         begin
            next_cause = `SVS_CAUSE_RESET;
         end
         if (uv_reset_req)
         begin
            next_cause[`SVS_CAUSE_UV] = 1'b1;
         end
         if (clkmon_reset_req)
         begin
            next_cause[`SVS_CAUSE_CLKMON] = 1'b1;
         end
         if (wdt_reset_req)
         begin
            next_cause[`SVS_CAUSE_WDT] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reset_cause_register <= `SVS_CAUSE_RESET;
      end
      else
      begin
         reset_cause_register <= next_cause;
      end
   end

   // Reset is held high through the async reset, which covers power-up
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         internal_reset <= 1'b1;
         undervoltage_irq <= 1'b0;
         reference_run <= 1'b0;
         comparator_run <= 1'b0;
         undervoltage_threshold <= `SVS_LEVEL_RESET;
      end
      else
      begin
         internal_reset <= poc_event || uv_reset_req || wdt_reset_req ||
            clkmon_reset_req;
         undervoltage_irq <= uv_irq_req;
         // With the clear built in, the reference runs permanently
         reference_run <= POC_ON || reference_enable;
         comparator_run <= comparator_enable;
         undervoltage_threshold <= level_code;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_uv_reset;
      comparator_enable && response_mode_select && uv_s && !other_reset;
   endsequence

   sequence s_cause_uv;
      internal_reset && reset_cause_register[`SVS_CAUSE_UV];
   endsequence

   property p_uv_reset;
      s_uv_reset |=> s_cause_uv;
   endproperty

   a_uv_reset_cause: assert property (p_uv_reset)
      else $error("undervoltage reset did not set cause bit");

   a_poc_clears_cause: assert property (poc_event |=> internal_reset &&
      reset_cause_register == 8'h00)
      else $error("clear reset left cause register nonzero");

   a_wdt_keeps_cause: assert property (wdt_reset_req && !poc_event |=>
      reset_cause_register[`SVS_CAUSE_WDT] && internal_reset)
      else $error("watchdog reset did not set its own flag");

   a_other_clears_ctrl: assert property (other_reset |=> !comparator_enable &&
      !reference_enable && !response_mode_select ##1 !comparator_run)
      else $error("control fields survived a non-undervoltage reset");

   a_uv_keeps_ctrl: assert property (s_uv_reset |=> $stable(comparator_enable) &&
      $stable(response_mode_select) && $stable(reference_enable))
      else $error("undervoltage reset changed control fields");

   a_irq_follows: assert property (comparator_enable && !response_mode_select
      && uv_s |=> undervoltage_irq)
      else $error("interrupt did not follow the flag");

   a_irq_off_mode: assert property (undervoltage_irq |-> $past(comparator_enable)
      && !$past(response_mode_select))
      else $error("interrupt raised outside interrupt mode");

   a_flag_disabled: assert property (setup && hit_ctrl && !comparator_enable |=>
      !prdata[`SVS_CTRL_FLAG])
      else $error("flag set while detection disabled");

   a_ref_locked: assert property (POC_ON |-> !reference_enable ##1 reference_run)
      else $error("reference enable changed while clear is built in");

   a_reserved_zero: assert property (setup && hit_ctrl && !pwrite |=>
      prdata[6:5] == 2'h0 && prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0)
      else $error("reserved control bits read nonzero");

   a_level_legal: assert property (level_code <= LEVEL_MAX)
      else $error("prohibited level code stored");

   a_flag_readonly: assert property (ctrl_wr && !pwdata[`SVS_CTRL_CMP_EN] |=>
      !ctrl_rd[`SVS_CTRL_FLAG])
      else $error("flag bit followed write data");

   a_clkmon_cause: assert property (clkmon_reset_req && !poc_event |=>
      reset_cause_register[`SVS_CAUSE_CLKMON] && internal_reset)
      else $error("clock monitor reset did not set its own flag");

   // A watchdog reset may only add flags, never drop one software has not read
   a_cause_kept: assert property (wdt_reset_req && !poc_event && !cause_rd |=>
      ($past(reset_cause_register) & ~reset_cause_register) == 8'h00)
      else $error("watchdog reset cleared another cause flag");

   a_irq_reset_mode: assert property (response_mode_select |=> !undervoltage_irq)
      else $error("interrupt raised in reset mode");

   a_cmp_off_quiet: assert property (!comparator_enable |=> !undervoltage_irq)
      else $error("interrupt raised with detection stopped");

   a_ctrl_write: assert property (ctrl_wr && !other_reset |=>
      comparator_enable == $past(pwdata[`SVS_CTRL_CMP_EN]) &&
      response_mode_select == $past(pwdata[`SVS_CTRL_MODE]))
      else $error("control write did not land");

   a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data above the byte lane nonzero");

   // Both comparator paths take exactly two edges through the synchroniser
   a_uv_sync_delay: assert property ($changed(uv_s) |->
      uv_s == $past(uv_below_raw, 2))
      else $error("detector comparator sync latency wrong");

   a_poc_sync_delay: assert property ($changed(poc_s) |->
      poc_s == $past(poc_below_raw, 2))
      else $error("clear comparator sync latency wrong");

   a_stop_keeps_irq: assert property (stop_mode && comparator_enable &&
      !response_mode_select && uv_s |=> undervoltage_irq)
      else $error("detection stopped working in stop mode");

   a_level_write: assert property (level_wr && level_ok && !other_reset |=>
      level_code == $past(pwdata[2:0]))
      else $error("legal level code not stored");

   a_level_refuse: assert property (level_wr && !level_ok && !other_reset |=>
      $stable(level_code))
      else $error("prohibited level code changed the level");
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the supply supervisor
// Assumes: Default build, clear built in at the low threshold
// Notes: Bus answers are taken at the rising edge with pready high; pin outputs mid-cycle, save the run and threshold checks taken at that edge
`timescale 1ns/10ps
`default_nettype none
`include "svs_consts.svh"

module tb_top;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic poc_raw = 1'b0;
   logic uv_raw = 1'b0;
   logic wdt = 1'b0;
   logic clkmon = 1'b0;
   logic stop = 1'b0;
   logic irq;
   logic int_rst;
   logic cmp_run;
   logic ref_run;
   logic [2:0] thr;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;

   always #4 sys_clk = ~sys_clk;

   svs_top dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .poc_below_raw(poc_raw), .uv_below_raw(uv_raw),
      .wdt_reset_req(wdt), .clkmon_reset_req(clkmon), .stop_mode(stop),
      .internal_reset(int_rst), .undervoltage_irq(irq), .comparator_run(cmp_run),
      .reference_run(ref_run), .undervoltage_threshold(thr));

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Request held until pready is seen; data taken at that same edge
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      // This wait ends when pready is seen, or at the bench timeout if it never is
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string m);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, exp}, m);
   endtask

   // Edge count n set per call; the two-flop sync plus the output register take three
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fails++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      rdc(`SVS_IDX_CTRL, `SVS_CTRL_RESET, "ctrl reset");
      rdc(`SVS_IDX_LEVEL, 8'h00, "level reset");
      rdc(`SVS_IDX_CAUSE, `SVS_CAUSE_RESET, "cause reset");
      chk(ref_run, 1'b1, "ref always on");
      apb(1'b0, 16'h0000, 8'h00);
      chk(err, 1'b1, "unmapped err");
      chk(rd, 32'h0, "unmapped data");
      $display("test reset_and_map done");

      wr(`SVS_IDX_CTRL, 8'hff);
      rdc(`SVS_IDX_CTRL, 8'h82, "ctrl fields");
      chk(cmp_run, 1'b1, "comparator on");
      chk(ref_run, 1'b1, "ref locked");
      wr(`SVS_IDX_LEVEL, 8'h06);
      wr(`SVS_IDX_LEVEL, 8'h07);
      rdc(`SVS_IDX_LEVEL, 8'h06, "prohibited code");
      chk(thr, 3'h6, "threshold out");
      $display("test fields done");

      // Clear is built in, so no reference wait comes before this
      wr(`SVS_IDX_CTRL, 8'h80);
      // Settling wait, 125 cycles per microsecond
      repeat (`SVS_CMP_SETTLE_US * 125) @(posedge sys_clk);
      stop <= 1'b1;
      uv_raw <= 1'b1;
      settle(4);
      chk(irq, 1'b1, "irq in stop");
      chk(int_rst, 1'b0, "no reset in irq mode");
      rdc(`SVS_IDX_CTRL, 8'h81, "flag set");
      wr(`SVS_IDX_CTRL, 8'h00);
      rdc(`SVS_IDX_CTRL, 8'h00, "flag off when stopped");
      settle(2);
      chk(irq, 1'b0, "irq stops");
      @(posedge sys_clk);
      uv_raw <= 1'b0;
      stop <= 1'b0;
      $display("test interrupt done");

      wr(`SVS_IDX_CTRL, 8'h82);
      @(posedge sys_clk);
      uv_raw <= 1'b1;
      settle(3);
      chk(int_rst, 1'b1, "uv reset");
      chk(irq, 1'b0, "no irq in reset mode");
      @(posedge sys_clk);
      uv_raw <= 1'b0;
      settle(5);
      chk(int_rst, 1'b0, "uv reset ends");
      rdc(`SVS_IDX_CTRL, 8'h82, "ctrl kept");
      rdc(`SVS_IDX_LEVEL, 8'h06, "level kept");
      @(posedge sys_clk);
      wdt <= 1'b1;
      @(posedge sys_clk);
      wdt <= 1'b0;
      @(negedge sys_clk);
      chk(int_rst, 1'b1, "wdt reset");
      rdc(`SVS_IDX_CAUSE, 8'h11, "cause accumulates");
      rdc(`SVS_IDX_CTRL, 8'h00, "ctrl cleared");
      rdc(`SVS_IDX_LEVEL, 8'h00, "level cleared");
      @(posedge sys_clk);
      clkmon <= 1'b1;
      @(posedge sys_clk);
      clkmon <= 1'b0;
      rdc(`SVS_IDX_CAUSE, 8'h02, "clkmon flag only");
      $display("test cause done");

      wdt <= 1'b1;
      @(posedge sys_clk);
      wdt <= 1'b0;
      wr(`SVS_IDX_LEVEL, 8'h03);
      poc_raw <= 1'b1;
      settle(4);
      chk(int_rst, 1'b1, "clear reset");
      @(posedge sys_clk);
      poc_raw <= 1'b0;
      settle(5);
      chk(int_rst, 1'b0, "clear ends");
      rdc(`SVS_IDX_CAUSE, 8'h00, "clear zeroes cause");
      rdc(`SVS_IDX_LEVEL, 8'h00, "clear zeroes level");
      $display("test clear done");
      results();
   end
endmodule
`default_nettype wire
